// ==== energy_accum_mode.sv ====
// energy accumulation mode control: configuration registers, phase b mapping,
// reverse power flags, line-cycle accumulation, clear-on-read, power factor source
// assumes one clock, samples valid on sample_strobe, zero crossings from pins
//
// Behaviour
// - source select 0 sets reverse flags 6, 7, 8 from total active power.
// - source select 1 sets reverse flags from fundamental active power.
// - accumulation config bit 7 resets to 1 and controls nothing.
// - phase b voltage is VB, VA-VC, -VA-VC or -VA by connection code.
// - reactive terms use voltage times current shifted by -90 degrees.
// - code 01 makes phase b rms report the line voltage VA-VC.
// - bit 0 puts all active accumulators into line-cycle mode.
// - bit 1 puts fundamental reactive accumulators into line-cycle mode.
// - bit 2 puts apparent accumulators into line-cycle mode.
// - bits 3..5 pick zero-crossing phases, reset 1, more phases shorten.
// - clear-on-read bit 6, reset 1, reading a regular-mode accumulator zeroes it.
// - power factor source 0 uses instantaneous phase powers.
// - source 1 uses line-cycle energies, updated once per half-cycle count.
`timescale 1ns/1ns
`default_nettype none
`include "energy_accum_map.svh"

module energy_accum_mode
    import energy_accum_pkg::*;
#(
    parameter int ACC_W = 32
) (
    // clock, reset, enable
    input  wire  logic                 core_clk,
    input  wire  logic                 rst,
    input  wire  logic                 clk_en,
    // register port
    input  wire  logic [15:0]          reg_addr,
    input  wire  logic [15:0]          reg_wdata,
    input  wire  logic                 reg_write,
    input  wire  logic                 reg_read,
    output var   logic [31:0]          reg_rdata,
    // signal path
    input  wire  logic                 sample_strobe,
    input  wire  phase_sample_t [2:0]  sample,
    input  wire  phase_power_t  [2:0]  power,
    input  wire  logic [2:0]           zero_cross_pin,
    // derived outputs
    output var   logic signed [16:0]   phase_b_voltage,
    output var   logic                 phase_b_line_rms,
    output var   logic [2:0]           reverse_power_flag,
    output var   logic signed [31:0]   power_factor
);

    // ********************************************
    // configuration registers
    // ********************************************
    logic [7:0]  accumulation_config;
    logic [7:0]  line_cycle_config;
    logic [15:0] half_cycle_count;
    logic [2:0]  status_clear;
    logic [2:0]  next_reverse;

    // software writes; accumulation_config bit 7 is forced to 1, all other written bits are stored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            accumulation_config <= `ACC_RESET;
            line_cycle_config   <= `LC_RESET;
            half_cycle_count    <= `HALF_CYCLE_RESET;
        end else if (clk_en && reg_write) begin
            if (reg_addr == `ACCUM_CONFIG_ADDR)
                accumulation_config <= {1'b1, reg_wdata[6:0]};
            if (reg_addr == `LINE_CYCLE_CONFIG_ADDR)
                line_cycle_config <= reg_wdata[7:0];
            if (reg_addr == `HALF_CYCLE_COUNT_ADDR)
                half_cycle_count <= reg_wdata;
        end
    end

    wire logic [1:0] connection_select  = accumulation_config[`ACC_CONNECTION_SELECT_LSB +: 2];
    wire logic       reverse_src_select = accumulation_config[`ACC_REVSEL_BIT];
    wire logic [2:0] lc_enable          = line_cycle_config[2:0];
    wire logic [2:0] zero_cross_select  = line_cycle_config[`LC_ZX_LSB +: 3];
    wire logic       clear_on_read      = line_cycle_config[`LC_CLR_READ_BIT];
    wire logic       pf_source_select   = line_cycle_config[`LC_PF_BIT];

    // ********************************************
    // zero-crossing synchronisers
    // ********************************************
    logic [2:0] zx_s1;
    logic [2:0] zx_s2;
    logic [2:0] zx_s3;
    logic [2:0] zx_state;

    // three flops; a change counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            zx_s1    <= 3'h0;
            zx_s2    <= 3'h0;
            zx_s3    <= 3'h0;
            zx_state <= 3'h0;
        end else if (clk_en) begin
            zx_s1 <= zero_cross_pin;
            zx_s2 <= zx_s1;
            zx_s3 <= zx_s2;
            for (int k = 0; k < 3; k++) begin
                if (zx_s2[k] == zx_s3[k])
                    zx_state[k] <= zx_s3[k];
            end
        end
    end

    // any edge is a half-cycle crossing on a selected phase
    wire logic [2:0] zx_event = (zx_state ^ zx_s3) & ~(zx_s2 ^ zx_s3) & zero_cross_select;

    function automatic logic [1:0] count_ones(input logic [2:0] v);
        count_ones = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction

    // ********************************************
    // phase b mapping and energy terms
    // ********************************************
    logic signed [16:0] vb_map;
    energy_term_t [2:0] term;

    // phase b voltage by connection code
    always_comb begin
        unique case (connection_select)
            2'b00:   vb_map = 17'(sample[1].v);
            2'b01:   vb_map = 17'(sample[0].v) - 17'(sample[2].v);
            2'b10:   vb_map = -17'(sample[0].v) - 17'(sample[2].v);
            2'b11:   vb_map = -17'(sample[0].v);
        endcase
    end

    // products; reactive uses the -90 degree current
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            if (k == 1) begin
                term[k].active   = 32'(vb_map) * 32'(sample[k].i);
                term[k].reactive = 32'(vb_map) * 32'(sample[k].iq);
            end else begin
                term[k].active   = 32'(sample[k].v) * 32'(sample[k].i);
                term[k].reactive = 32'(sample[k].v) * 32'(sample[k].iq);
            end
        end
    end

    // mapped phase b voltage and line-rms indication
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_b_voltage  <= 17'h00000;
            phase_b_line_rms <= 1'b0;
        end else if (clk_en) begin
            phase_b_voltage  <= vb_map;
            phase_b_line_rms <= (connection_select == 2'b01);
        end
    end

    // ********************************************
    // reverse power flags
    // ********************************************
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            if (reverse_src_select)
                next_reverse[k] = power[k].fund_p[31];
            else
                next_reverse[k] = power[k].total_p[31];
        end
    end

    // sticky flags; set wins over status write clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            reverse_power_flag <= 3'h0;
        else if (clk_en)
            reverse_power_flag <= (reverse_power_flag & ~status_clear)
                | (sample_strobe ? next_reverse : 3'h0);
    end

    assign status_clear = (reg_write && reg_addr == `STATUS_ADDR) ?
        reg_wdata[`ST_REV_C_BIT:`ST_REV_A_BIT] : 3'h0;

    // ********************************************
    // line-cycle period control
    // ********************************************
    accum_state_t state;
    logic [15:0]  zx_count;
    logic [2:0]   lc_mode;
    wire logic [1:0]  zx_hits = count_ones(zx_event);
    wire logic        period_end = (state == ACC_WAIT) &&
        (zx_count + 16'(zx_hits) >= half_cycle_count);

    // more selected phases give more crossings, shortening the period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state    <= ACC_FREE;
            zx_count <= 16'h0000;
            lc_mode  <= 3'h0;
        end else if (clk_en) begin
            unique case (state)
                ACC_FREE: begin
                    lc_mode <= lc_enable;
                    if (lc_enable != 3'h0) begin
                        state    <= ACC_WAIT;
                        zx_count <= 16'h0000;
                    end
                end
                ACC_WAIT: begin
                    zx_count <= zx_count + 16'(zx_hits);
                    if (period_end)
                        state <= ACC_LATCH;
                end
                ACC_LATCH: begin
                    lc_mode  <= lc_enable;
                    zx_count <= 16'h0000;
                    state    <= (lc_enable != 3'h0) ? ACC_WAIT : ACC_FREE;
                end
            endcase
        end
    end

    // ********************************************
    // energy accumulators
    // ********************************************
    // index: 0 total active, 1 fund active, 2 fund reactive, 3 apparent
    logic signed [ACC_W-1:0] run_acc [4][3];
    logic signed [ACC_W-1:0] out_acc [4][3];
    wire logic [3:0] kind_lc = {lc_mode[2], lc_mode[1], lc_mode[0], lc_mode[0]};
    wire logic [3:0] read_sel = 4'(reg_addr - `ENERGY_BASE_ADDR);
    wire logic       energy_read = reg_read &&
        (reg_addr >= `ENERGY_BASE_ADDR) && (reg_addr < `ENERGY_BASE_ADDR + 16'd12);

    function automatic logic signed [ACC_W-1:0] pick_term(input int kind, input int ph);
        unique case (kind)
            0:       pick_term = ACC_W'(power[ph].total_p);
            1:       pick_term = ACC_W'(power[ph].fund_p);
            2:       pick_term = ACC_W'(term[ph].reactive);
            default: pick_term = ACC_W'(power[ph].apparent_p);
        endcase
    endfunction

    // regular mode accumulates into the visible register; line-cycle latches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int t = 0; t < 4; t++)
                for (int p = 0; p < 3; p++) begin
                    run_acc[t][p] <= '0;
                    out_acc[t][p] <= '0;
                end
        end else if (clk_en) begin
            for (int t = 0; t < 4; t++)
                for (int p = 0; p < 3; p++) begin
                    if (kind_lc[t]) begin
                        if (state == ACC_LATCH) begin
                            out_acc[t][p] <= run_acc[t][p];
                            run_acc[t][p] <= '0;
                        end else if (sample_strobe && state == ACC_WAIT)
                            run_acc[t][p] <= run_acc[t][p] + pick_term(t, p);
                    end else begin
                        if (energy_read && clear_on_read && read_sel == 4'(t * 3 + p))
                            out_acc[t][p] <= sample_strobe ? pick_term(t, p) : '0;
                        else if (sample_strobe)
                            out_acc[t][p] <= out_acc[t][p] + pick_term(t, p);
                    end
                end
        end
    end

    // ********************************************
    // power factor
    // ********************************************
    // ratio of active to apparent, phase a, in Q1.30
    function automatic logic signed [31:0] pf_ratio(input logic signed [ACC_W-1:0] p,
                                                    input logic signed [ACC_W-1:0] s);
        logic signed [63:0] num;
        num = 64'(p) <<< 30;
        pf_ratio = (s == '0) ? 32'h00000000 : 32'(num / 64'(s));
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            power_factor <= 32'h00000000;
        else if (clk_en) begin
            if (!pf_source_select && sample_strobe)
                power_factor <= pf_ratio(ACC_W'(power[0].total_p),
                                         ACC_W'(power[0].apparent_p));
            else if (pf_source_select && state == ACC_LATCH)
                power_factor <= pf_ratio(run_acc[0][0], run_acc[3][0]);
        end
    end

    // ********************************************
    // register read port
    // ********************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else if (clk_en && reg_read) begin
            if (energy_read)
                reg_rdata <= 32'(out_acc[read_sel / 3][read_sel % 3]);
            else if (reg_addr == `ACCUM_CONFIG_ADDR)
                reg_rdata <= {24'h000000, accumulation_config};
            else if (reg_addr == `LINE_CYCLE_CONFIG_ADDR)
                reg_rdata <= {24'h000000, line_cycle_config};
            else if (reg_addr == `HALF_CYCLE_COUNT_ADDR)
                reg_rdata <= {16'h0000, half_cycle_count};
            else if (reg_addr == `STATUS_ADDR)
                reg_rdata <= {23'h000000, reverse_power_flag, 6'h00};
            else
                reg_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ==== energy_accum_map.svh ====
// constants for the energy accumulation mode control block
// assumes inclusion by bare name from the design, checker and bench files
`ifndef ENERGY_ACCUM_MAP_SVH
`define ENERGY_ACCUM_MAP_SVH

// register offsets (accumulation_config offset is chosen)
`define ACCUM_CONFIG_ADDR      16'hE701
`define LINE_CYCLE_CONFIG_ADDR 16'hE702
`define HALF_CYCLE_COUNT_ADDR  16'hE703
`define STATUS_ADDR            16'hE704
`define ENERGY_BASE_ADDR       16'hE710

// accumulation_config fields
`define ACC_CONNECTION_SELECT_LSB      4
`define ACC_REVSEL_BIT      6
`define ACC_SPARE_BIT       7
`define ACC_RESET           8'h80

// line_cycle_config fields
`define LC_ACTIVE_BIT       0
`define LC_REACTIVE_BIT     1
`define LC_APPARENT_BIT     2
`define LC_ZX_LSB           3
`define LC_CLR_READ_BIT     6
`define LC_PF_BIT           7
`define LC_RESET            8'h78

// status fields
`define ST_REV_A_BIT        6
`define ST_REV_B_BIT        7
`define ST_REV_C_BIT        8

`define HALF_CYCLE_RESET    16'h0064

`endif

// ==== energy_accum_pkg.sv ====
// types for the energy accumulation mode control block
// assumes nothing beyond the map header
package energy_accum_pkg;

    // one phase sample: voltage, current and current shifted by -90 degrees
    typedef struct packed {
        logic signed [15:0] v;
        logic signed [15:0] i;
        logic signed [15:0] iq;
    } phase_sample_t;

    // per-phase power inputs from the signal path
    typedef struct packed {
        logic signed [31:0] total_p;
        logic signed [31:0] fund_p;
        logic        [31:0] apparent_p;
    } phase_power_t;

    // energy terms after connection mapping
    typedef struct packed {
        logic signed [31:0] active;
        logic signed [31:0] reactive;
    } energy_term_t;

    typedef enum logic [2:0] {
        ACC_FREE  = 3'b001,
        ACC_WAIT  = 3'b010,
        ACC_LATCH = 3'b100
    } accum_state_t;

endpackage

// ==== energy_accum_mode_props.sv ====
// checker for the energy accumulation mode block, watching top ports only
// assumes one clock domain and binding onto energy_accum_mode
`timescale 1ns/1ns
`default_nettype none
`include "energy_accum_map.svh"

module energy_accum_mode_props
    import energy_accum_pkg::*;
(
    // clock, reset, enable
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic                clk_en,
    // register port
    input wire logic [15:0]         reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic                reg_write,
    input wire logic                reg_read,
    input wire logic [31:0]         reg_rdata,
    // signal path and outputs
    input wire logic                sample_strobe,
    input wire phase_power_t [2:0]  power,
    input wire logic                phase_b_line_rms,
    input wire logic [2:0]          reverse_power_flag
);
    // ****************************************
    // helper logic and properties
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic rev_sel;
    logic cfg_wr;
    logic st_wr;
    logic rd;
    logic mapped;

    // decoded bus requests
    assign cfg_wr = clk_en && reg_write && reg_addr == `ACCUM_CONFIG_ADDR;
    assign st_wr  = clk_en && reg_write && reg_addr == `STATUS_ADDR;
    assign rd     = clk_en && reg_read;
    assign mapped = (reg_addr >= `ACCUM_CONFIG_ADDR && reg_addr <= `STATUS_ADDR) ||
                    (reg_addr >= `ENERGY_BASE_ADDR && reg_addr <= `ENERGY_BASE_ADDR + 16'h000B);

    // shadow of the reverse source select bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            rev_sel <= 1'b0;
        else if (cfg_wr)
            rev_sel <= reg_wdata[`ACC_REVSEL_BIT];
    end

    a_rdata_hold: assert property (!$past(rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_spare_one: assert property (rd && reg_addr == `ACCUM_CONFIG_ADDR |=> reg_rdata[7])
        else $error("spare config bit read as zero");
    a_unmapped_zero: assert property (rd && !mapped |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_delta_rms: assert property (cfg_wr ##1 !cfg_wr [*3] |->
        phase_b_line_rms == ($past(reg_wdata[5:4], 3) == 2'b01))
        else $error("phase b line rms flag wrong for code");
    a_flag_sticky: assert property (!$past(st_wr) |->
        (reverse_power_flag & $past(reverse_power_flag)) == $past(reverse_power_flag))
        else $error("reverse flag fell without clear");
    a_flag_cause: assert property ((reverse_power_flag & ~$past(reverse_power_flag)) != 3'h0
        |-> $past(sample_strobe && clk_en))
        else $error("reverse flag rose without a sample");
    a_total_src: assert property (sample_strobe && clk_en && !rev_sel &&
        power[2].total_p[31] |=> reverse_power_flag[2])
        else $error("total power did not set reverse flag");
    a_fund_src: assert property (sample_strobe && clk_en && rev_sel &&
        power[1].fund_p[31] |=> reverse_power_flag[1])
        else $error("fundamental power did not set reverse flag");
    a_freeze_hold: assert property (!clk_en |=> $stable(reverse_power_flag))
        else $error("flags moved while frozen");

    // main scenarios
    c_energy_read: cover property (rd && reg_addr == `ENERGY_BASE_ADDR);
    c_delta_code: cover property ($rose(phase_b_line_rms));
    c_flag_rise: cover property (reverse_power_flag != 3'h0);
endmodule

bind energy_accum_mode energy_accum_mode_props energy_accum_mode_props_inst (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .power(power),
    .phase_b_line_rms(phase_b_line_rms), .reverse_power_flag(reverse_power_flag));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the energy accumulation mode block
// assumes the map header, package and design are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "energy_accum_map.svh"

module tb_top
    import energy_accum_pkg::*;
;
    // ****************************************
    // signals, clock, helpers
    // ****************************************
    logic                core_clk, rst, clk_en, reg_write, reg_read, sample_strobe;
    logic [15:0]         reg_addr, reg_wdata;
    logic [31:0]         reg_rdata, r1, r2;
    phase_sample_t [2:0] sample;
    phase_power_t  [2:0] power;
    logic [2:0]          zero_cross_pin, want, reverse_power_flag;
    logic signed [16:0]  phase_b_voltage;
    logic                phase_b_line_rms;
    logic signed [31:0]  power_factor;
    int                  num_errors, comparisons, cycles, seed;

    energy_accum_mode #(.ACC_W(32)) energy_accum_mode_inst (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .sample(sample),
        .power(power), .zero_cross_pin(zero_cross_pin), .phase_b_voltage(phase_b_voltage),
        .phase_b_line_rms(phase_b_line_rms), .reverse_power_flag(reverse_power_flag),
        .power_factor(power_factor));

    // free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    task automatic wrap_up;
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    // read data is registered on the edge after the strobe and held until the next read
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask

    // fresh random samples and powers
    task automatic rnd;
        @(posedge core_clk);
        for (int p = 0; p < 3; p++) begin
            sample[p] <= {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
            power[p] <= {32'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        end
        #1;
    endtask

    task automatic pulse;
        @(posedge core_clk);
        sample_strobe <= 1'b1;
        @(posedge core_clk);
        sample_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // three edges on the chosen crossing pins
    task automatic tog(input logic [2:0] m);
        repeat (3) begin
            @(posedge core_clk);
            zero_cross_pin <= zero_cross_pin ^ m;
            repeat (8) @(posedge core_clk);
        end
    endtask

    function automatic logic signed [16:0] exp_vb(input logic [1:0] c,
                                                  input phase_sample_t [2:0] s);
        logic signed [16:0] va, vb, vc;
        va = s[0].v;
        vb = s[1].v;
        vc = s[2].v;
        case (c)
            2'b00: exp_vb = vb;
            2'b01: exp_vb = va - vc;
            2'b10: exp_vb = -va - vc;
            default: exp_vb = -va;
        endcase
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {num_errors, comparisons, cycles} = '0;
        seed = 10406;
        {rst, clk_en} = 2'b11;
        {reg_write, reg_read, sample_strobe} = 3'b000;
        {reg_addr, reg_wdata} = '0;
        {sample, power} = '0;
        zero_cross_pin = 3'b000;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // reset values, spare bit, unmapped place
        rd_chk(`ACCUM_CONFIG_ADDR, 32'h80, "accumulation_config");
        rd_chk(`LINE_CYCLE_CONFIG_ADDR, 32'h78, "line_cycle_config");
        wr(`ACCUM_CONFIG_ADDR, 16'h0000);
        rd_chk(`ACCUM_CONFIG_ADDR, 32'h80, "spare bit");
        rd_chk(16'hE7FF, 32'h0, "unmapped");
        // every connection code
        for (int c = 0; c < 4; c++) begin
            rnd;
            wr(`ACCUM_CONFIG_ADDR, 16'(c << 4));
            pulse;
            chk("phase_b_voltage", 32'(exp_vb(2'(c), sample)), 32'(phase_b_voltage));
            chk("phase_b_line_rms", 32'(c == 1), 32'(phase_b_line_rms));
        end
        // power factor from instantaneous phase a powers
        @(posedge core_clk);
        power[0] <= {32'h00001000, 32'h00000000, 32'h00002000};
        pulse;
        chk("power_factor", 32'h20000000, 32'(power_factor));
        // reverse flags from either source, last pass frozen by clk_en
        for (int i = 0; i < 8; i++) begin
            wr(`ACCUM_CONFIG_ADDR, i[0] ? 16'h0040 : 16'h0000);
            wr(`STATUS_ADDR, 16'h01C0);
            rnd;
            for (int p = 0; p < 3; p++)
                want[p] = (i != 7) && (i[0] ? power[p].fund_p[31] : power[p].total_p[31]);
            @(posedge core_clk);
            clk_en <= (i != 7);
            pulse;
            @(posedge core_clk);
            clk_en <= 1'b1;
            chk("reverse_power_flag", 32'(want), 32'(reverse_power_flag));
            rd(`STATUS_ADDR, r1);
            chk("status flags", 32'(want), 32'(r1[8:6]));
        end
        // clear-on-read on, then off
        wr(`LINE_CYCLE_CONFIG_ADDR, 16'h0078);
        rd(`ENERGY_BASE_ADDR + 16'h0006, r1);
        rnd;
        pulse;
        r2 = 32'(sample[0].v) * 32'(sample[0].iq);
        rd_chk(`ENERGY_BASE_ADDR + 16'h0006, r2, "reactive energy a");
        rd(`ENERGY_BASE_ADDR, r1);
        rd_chk(`ENERGY_BASE_ADDR, 32'h0, "energy after clearing read");
        wr(`LINE_CYCLE_CONFIG_ADDR, 16'h0038);
        rnd;
        pulse;
        rd(`ENERGY_BASE_ADDR, r1);
        rd_chk(`ENERGY_BASE_ADDR, r1, "energy kept");
        // line-cycle on phase b crossings only
        wr(`HALF_CYCLE_COUNT_ADDR, 16'h0002);
        wr(`LINE_CYCLE_CONFIG_ADDR, 16'h0011);
        rd(`ENERGY_BASE_ADDR, r1);
        rnd;
        pulse;
        tog(3'b001);
        rd_chk(`ENERGY_BASE_ADDR, r1, "line-cycle energy held");
        tog(3'b010);
        rd(`ENERGY_BASE_ADDR, r2);
        chk("line-cycle latch", 32'(power[0].total_p), r2);
        // power factor from line-cycle energies, all enables on, clearing read off
        wr(`LINE_CYCLE_CONFIG_ADDR, 16'h0097);
        tog(3'b010);
        @(posedge core_clk);
        power[0] <= {32'hFFFFF000, 32'h00000000, 32'h00002000};
        pulse;
        tog(3'b010);
        chk("power_factor line-cycle", 32'hE0000000, 32'(power_factor));
        wrap_up;
    end
endmodule
`default_nettype wire
